// [core/fps_defs.vh]
// Constants for the programmer-mode status and command block.
// Assumes a single 40 MHz clock; included by bare name from core files.
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH

// Clock rate and lockout times
`define FPS_CLK_KHZ        40000
`define FPS_T_OSC_MS       10
`define FPS_T_SETUP_MS     10
`define FPS_T_STRD_US      20
`define FPS_CLK_MHZ        40

// Command codes written by the programmer on the data bus
`define FPS_CMD_READ       8'h00
`define FPS_CMD_PROG       8'h40
`define FPS_CMD_ERASE      8'h20
`define FPS_CMD_ERASE_CFM  8'h20
`define FPS_CMD_STATUS     8'h71

// Status return byte fields
`define FPS_ST_ABNORMAL    7
`define FPS_ST_CMD_ERR     6
`define FPS_ST_PROG_ERR    5
`define FPS_ST_ERASE_ERR   4
`define FPS_ST_COUNT_ERR   1
`define FPS_ST_ADDR_ERR    0
`define FPS_ST_RESET       8'h00
`define FPS_ST_DEF_MASK    8'hf3

// Polling byte values, bits 7 and 6
`define FPS_POLL_RUN       2'b00
`define FPS_POLL_FAIL      2'b10
`define FPS_POLL_ADDR      2'b01
`define FPS_POLL_OK        2'b11
`define FPS_POLL_PAD       6'h00

// Auto-program page geometry
`define FPS_PAGE_BITS      7
`define FPS_PAGE_LAST      7'h7f
`define FPS_PAGE_ZERO      7'h00

// Idle data output
`define FPS_DATA_IDLE      8'h00

`endif

// [core/fps_status.v]
// Programmer-mode command acceptance, polling and status return logic.
// Assumes programmer pins are already synchronous to sys_clk and that an
// internal flash engine performs the actual program and erase cycles.
//
// Function
// - Status read mode reports abnormal end kind
// - Status code kept until non-status command write
// - Status byte bits 7,6,5,4,1,0, reset zero
// - Status bits 3 and 2 undefined
// - Bit 7 polls operation in progress
// - Bit 6 polls normal versus abnormal end
// - Polling 00 running, 10/01 abnormal, 11 normal
// - Commands ignored during both 10 ms lockouts
// - Enter memory read after setup time
// - Write-enable status reads 1 when programming; here it copies program_enable_flag one cycle later
// - Polling bits held until next command write
// - Misaligned program address writes, flags error
`timescale 1ns/10ps
`default_nettype none
`include "fps_defs.vh"

module fps_status #(
    parameter ADDR_W       = 18,
    parameter TMR_W        = 20,
    parameter OSC_CYCLES   = `FPS_T_OSC_MS * `FPS_CLK_KHZ,
    parameter SETUP_CYCLES = `FPS_T_SETUP_MS * `FPS_CLK_KHZ
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              rst_n,
    // Programmer pins
    input  wire              ce_n,
    input  wire              oe_n,
    input  wire              we_n,
    input  wire [ADDR_W-1:0] addr,
    input  wire [7:0]        data_in,
    output reg  [7:0]        data_out,
    output reg               data_oe_n,
    // Memory read path
    output reg  [ADDR_W-1:0] mem_addr,
    input  wire [7:0]        mem_rdata,
    // Page buffer load toward the flash engine
    output reg               load_wr,
    output reg  [6:0]        load_idx,
    output reg  [7:0]        load_data,
    output reg  [ADDR_W-1:0] load_base,
    // Flash engine control
    output reg               prog_start,
    output reg               erase_start,
    input  wire              eng_done,
    input  wire              eng_fail,
    input  wire              eng_count_over,
    // Protection pin and its readback bit
    input  wire              program_enable_flag,
    output reg               fmc1_write_enable,
    // Mode indication
    output wire              cmd_ready
);

    // Operating states
    localparam [2:0] ST_OSC   = 3'd0;
    localparam [2:0] ST_SETUP = 3'd1;
    localparam [2:0] ST_READ  = 3'd2;
    localparam [2:0] ST_PLOAD = 3'd3;
    localparam [2:0] ST_BUSY  = 3'd4;
    localparam [2:0] ST_POLL  = 3'd5;
    localparam [2:0] ST_STAT  = 3'd6;
    localparam [2:0] ST_ECFM  = 3'd7;

    reg [2:0]        state_q;
    reg [2:0]        state_d;
    reg [7:0]        status_q;
    reg [7:0]        status_d;
    reg [1:0]        poll_q;
    reg [1:0]        poll_d;
    reg [6:0]        idx_q;
    reg [6:0]        idx_d;
    reg              erase_op_q;
    reg              erase_op_d;
    reg              addr_err_q;
    reg              addr_err_d;
    reg              we_n_q;
    reg [7:0]        data_d;
    reg              oe_n_d;

    wire             osc_done;
    wire             setup_done;
    wire             wr_evt;
    wire             drive_ok;

    // Oscillation stabilisation, runs from reset release
    fps_timer #(
        .WIDTH (TMR_W),
        .COUNT (OSC_CYCLES)
    ) u_osc_tmr (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .en      (1'b1),
        .done_q  (osc_done)
    );

    // Programmer mode setup, starts once the oscillator has settled
    fps_timer #(
        .WIDTH (TMR_W),
        .COUNT (SETUP_CYCLES)
    ) u_setup_tmr (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .en      (osc_done),
        .done_q  (setup_done)
    );

    // Write strobe: rising edge of write-enable with chip selected
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            we_n_q <= 1'b1;
        end else begin
            we_n_q <= we_n;
        end
    end

    assign wr_evt    = !we_n_q && we_n && !ce_n;
    assign cmd_ready = (state_q == ST_READ) || (state_q == ST_POLL) ||
                       (state_q == ST_STAT);

    // Next-state, status and polling decisions
    always @* begin
        state_d     = state_q;
        status_d    = status_q;
        poll_d      = poll_q;
        idx_d       = idx_q;
        erase_op_d  = erase_op_q;
        addr_err_d  = addr_err_q;
        case (state_q)
            ST_OSC: begin
                // Writes in lockout are dropped without a trace
                if (osc_done) begin
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (setup_done) begin
                    state_d = ST_READ;
                end
            end
            ST_READ, ST_POLL, ST_STAT: begin
                if (wr_evt) begin
                    // Any command other than status read drops the old code
                    if (data_in != `FPS_CMD_STATUS) begin
                        status_d = `FPS_ST_RESET;
                    end
                    case (data_in)
                        `FPS_CMD_READ: begin
                            state_d = ST_READ;
                        end
                        `FPS_CMD_PROG: begin
                            state_d    = ST_PLOAD;
                            idx_d      = `FPS_PAGE_ZERO;
                            erase_op_d = 1'b0;
                            addr_err_d = 1'b0;
                        end
                        `FPS_CMD_ERASE: begin
                            state_d    = ST_ECFM;
                            erase_op_d = 1'b1;
                            addr_err_d = 1'b0;
                        end
                        `FPS_CMD_STATUS: begin
                            state_d = ST_STAT;
                        end
                        default: begin
                            // Unknown command is reported, not executed
                            state_d = ST_READ;
                            status_d[`FPS_ST_ABNORMAL] = 1'b1;
                            status_d[`FPS_ST_CMD_ERR]  = 1'b1;
                        end
                    endcase
                end
            end
            ST_ECFM: begin
                // Erase needs its second command cycle before it starts
                if (wr_evt) begin
                    if (data_in == `FPS_CMD_ERASE_CFM) begin
                        state_d = ST_BUSY;
                        poll_d  = `FPS_POLL_RUN;
                    end else begin
                        state_d = ST_READ;
                        status_d[`FPS_ST_ABNORMAL] = 1'b1;
                        status_d[`FPS_ST_CMD_ERR]  = 1'b1;
                    end
                end
            end
            ST_PLOAD: begin
                if (wr_evt) begin
                    // Misaligned page start still loads, but is flagged
                    if (idx_q == `FPS_PAGE_ZERO &&
                        addr[`FPS_PAGE_BITS-1:0] != `FPS_PAGE_ZERO) begin
                        addr_err_d = 1'b1;
                        status_d[`FPS_ST_ABNORMAL] = 1'b1;
                        status_d[`FPS_ST_ADDR_ERR] = 1'b1;
                    end
                    idx_d = idx_q + 7'h01;
                    if (idx_q == `FPS_PAGE_LAST) begin
                        state_d = ST_BUSY;
                        poll_d  = `FPS_POLL_RUN;
                    end
                end
            end
            ST_BUSY: begin
                // Command writes during the operation are not accepted
                if (eng_done) begin
                    state_d = ST_POLL;
                    if (eng_fail) begin
                        poll_d = `FPS_POLL_FAIL;
                        status_d[`FPS_ST_ABNORMAL] = 1'b1;
                        if (erase_op_q) begin
                            status_d[`FPS_ST_ERASE_ERR] = 1'b1;
                        end else begin
                            status_d[`FPS_ST_PROG_ERR] = 1'b1;
                        end
                        if (eng_count_over) begin
                            status_d[`FPS_ST_COUNT_ERR] = 1'b1;
                        end
                    end else if (addr_err_q) begin
                        poll_d = `FPS_POLL_ADDR;
                    end else begin
                        poll_d = `FPS_POLL_OK;
                    end
                end
            end
            default: begin
                state_d = ST_OSC;
            end
        endcase
    end

    // Core state registers
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q    <= ST_OSC;
            status_q   <= `FPS_ST_RESET;
            poll_q     <= `FPS_POLL_RUN;
            idx_q      <= `FPS_PAGE_ZERO;
            erase_op_q <= 1'b0;
            addr_err_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            status_q   <= status_d;
            poll_q     <= poll_d;
            idx_q      <= idx_d;
            erase_op_q <= erase_op_d;
            addr_err_q <= addr_err_d;
        end
    end

    // Page load and engine start pulses
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            load_wr     <= 1'b0;
            load_idx    <= `FPS_PAGE_ZERO;
            load_data   <= `FPS_DATA_IDLE;
            load_base   <= {ADDR_W{1'b0}};
            prog_start  <= 1'b0;
            erase_start <= 1'b0;
        end else begin
            load_wr     <= (state_q == ST_PLOAD) && wr_evt;
            prog_start  <= (state_q == ST_PLOAD) && wr_evt &&
                           (idx_q == `FPS_PAGE_LAST);
            erase_start <= (state_q == ST_ECFM) && wr_evt &&
                           (data_in == `FPS_CMD_ERASE_CFM);
            if ((state_q == ST_PLOAD) && wr_evt) begin
                load_idx  <= idx_q;
                load_data <= data_in;
                if (idx_q == `FPS_PAGE_ZERO) begin
                    // The whole page goes to the captured base address
                    load_base <= addr;
                end
            end
        end
    end

    // Read data selection by mode; undefined bits read as zero
    always @* begin
        case (state_q)
            ST_READ: begin
                data_d = mem_rdata;
            end
            ST_BUSY: begin
                data_d = {`FPS_POLL_RUN, `FPS_POLL_PAD};
            end
            ST_POLL: begin
                data_d = {poll_q, `FPS_POLL_PAD};
            end
            ST_STAT: begin
                data_d = status_q & `FPS_ST_DEF_MASK;
            end
            default: begin
                data_d = `FPS_DATA_IDLE;
            end
        endcase
    end

    // The bus is only driven in a mode that has something to show
    assign drive_ok = (state_q == ST_READ) || (state_q == ST_BUSY) ||
                      (state_q == ST_POLL) || (state_q == ST_STAT);

    always @* begin
        oe_n_d = !(!ce_n && !oe_n && drive_ok);
    end

    // Output registers; one cycle of pin latency, two from address to array read data
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            data_out          <= `FPS_DATA_IDLE;
            data_oe_n         <= 1'b1;
            mem_addr          <= {ADDR_W{1'b0}};
            fmc1_write_enable <= 1'b0;
        end else begin
            data_out          <= data_d;
            data_oe_n         <= oe_n_d;
            mem_addr          <= addr;
            fmc1_write_enable <= program_enable_flag;
        end
    end

endmodule

`default_nettype wire

// [core/fps_timer.v]
// Lockout timer: counts enabled cycles and raises done at a set count.
// Assumes a synchronous active-low reset on the shared system clock.
`timescale 1ns/10ps
`default_nettype none

module fps_timer #(
    parameter WIDTH = 20,
    parameter COUNT = 400000
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst_n,
    // Control
    input  wire             en,
    output reg              done_q
);

    localparam [WIDTH-1:0] LAST = COUNT - 1;

    reg [WIDTH-1:0] cnt_q;

    // Count while enabled, then hold done until reset
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q  <= {WIDTH{1'b0}};
            done_q <= 1'b0;
        end else if (en && !done_q) begin
            if (cnt_q == LAST) begin
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// [tb/fps_engine_model.sv]
// Flash engine and array stand-in facing the status block.
// Assumes the bench sets latency and outcome before each start.
`timescale 1ns/10ps
`default_nettype none
module fps_engine_model (
    // Clock
    input  wire logic        sys_clk,
    // Start requests and outcome chosen by the bench
    input  wire logic        prog_start,
    input  wire logic        erase_start,
    input  wire logic [7:0]  lat,
    input  wire logic        fail_cfg,
    input  wire logic        over_cfg,
    // Completion and array read
    input  wire logic [17:0] mem_addr,
    output var  logic        eng_done,
    output var  logic        eng_fail,
    output var  logic        eng_count_over,
    output var  logic [7:0]  mem_rdata
);
    logic [8:0] left_q = 9'h000;
    initial eng_done = 1'b0;
    // Outcome lines read inverted outside the done pulse, so nothing unqualified looks right
    always @(posedge sys_clk) begin
        eng_done       <= left_q == 9'h001;
        eng_fail       <= (left_q == 9'h001) ? fail_cfg : !fail_cfg;
        eng_count_over <= (left_q == 9'h001) ? over_cfg : !over_cfg;
        if (prog_start || erase_start) left_q <= {1'b0, lat};
        else if (left_q != 9'h000) left_q <= left_q - 9'h001;
    end
    // Array contents follow the address
    assign mem_rdata = mem_addr[7:0] ^ 8'ha5;
endmodule
`default_nettype wire

// [tb/fps_status_chk.sv]
// Checker for the programmer-mode status block, bound to its top module.
// Assumes the bound instance hands down its lockout counts.
`timescale 1ns/10ps
`default_nettype none
module fps_status_chk #(
    parameter OSC_CYCLES   = 20,
    parameter SETUP_CYCLES = 20
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Programmer pins
    input wire logic       ce_n,
    input wire logic       oe_n,
    input wire logic       we_n,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_n,
    // Engine and mode
    input wire logic       prog_start,
    input wire logic       erase_start,
    input wire logic       eng_done,
    input wire logic       eng_fail,
    input wire logic       program_enable_flag,
    input wire logic       fmc1_write_enable,
    input wire logic       cmd_ready
);
    localparam int LOCK = OSC_CYCLES + SETUP_CYCLES;
    logic [15:0] cnt_q;
    logic        busy_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Edges since reset, and engine busy span lagging the start by one edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q  <= 16'h0000;
            busy_q <= 1'b0;
        end else begin
            if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
            if (prog_start || erase_start) busy_q <= 1'b1;
            else if (eng_done) busy_q <= 1'b0;
        end
    end
    property p_hiz;
        ce_n || oe_n |=> data_oe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("bus driven while deselected");
    property p_drive;
        !ce_n && !oe_n && cmd_ready && we_n && $past(we_n) && $past(we_n, 2) |=> !data_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("read not driven");
    property p_flag;
        $changed(program_enable_flag) |=> fmc1_write_enable == $past(program_enable_flag);
    endproperty
    a_flag: assert property (p_flag) else $error("enable bit not following pin");
    property p_lock;
        cnt_q < LOCK - 2 |-> !cmd_ready;
    endproperty
    a_lock: assert property (p_lock) else $error("commands open in lockout");
    property p_ready;
        cnt_q == LOCK + 4 |-> cmd_ready;
    endproperty
    a_ready: assert property (p_ready) else $error("no read mode after setup");
    property p_busy;
        busy_q && $past(busy_q) && !data_oe_n |-> data_out == 8'h00;
    endproperty
    a_busy: assert property (p_busy) else $error("polling not zero while busy");
    property p_fail;
        busy_q && eng_done && eng_fail ##2 !data_oe_n |-> data_out == 8'h80;
    endproperty
    a_fail: assert property (p_fail) else $error("bad abnormal polling");
    property p_ok;
        busy_q && eng_done && !eng_fail ##2 !data_oe_n |-> data_out[6] && data_out[5:0] == 6'h00;
    endproperty
    a_ok: assert property (p_ok) else $error("bad normal polling");
endmodule
bind fps_status fps_status_chk #(.OSC_CYCLES(OSC_CYCLES), .SETUP_CYCLES(SETUP_CYCLES)) chk_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .prog_start(prog_start),
    .erase_start(erase_start), .eng_done(eng_done), .eng_fail(eng_fail),
    .program_enable_flag(program_enable_flag), .fmc1_write_enable(fmc1_write_enable),
    .cmd_ready(cmd_ready));
`default_nettype wire

// [tb/fps_status_tb.sv]
// Self-checking bench for the programmer-mode status block.
// Assumes the engine model file and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module fps_status_tb;
    logic        sys_clk, rst_n, ce_n, oe_n, we_n, look, program_enable_flag;
    logic        prog_start, erase_start, eng_done, eng_fail, eng_count_over;
    logic        data_oe_n, fmc1_write_enable, cmd_ready, fail_cfg, over_cfg;
    logic [17:0] addr, mem_addr, base, lb;
    logic        lw;
    logic [6:0]  li;
    int          lcnt = 0;
    logic [7:0]  data_in, data_out, mem_rdata, lat, m;
    logic [9:0]  e;
    logic [9:0]  exp_q[$];
    logic [19:0] t;
    logic [19:0] tbl [0:5] = '{20'h8c000, 20'h0c000, 20'h44081, 20'h280a0, 20'h380a2, 20'hb8092};
    int          i, j, bad_count, compares;
    fps_status #(.OSC_CYCLES(20), .SETUP_CYCLES(20)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .load_wr(lw), .load_idx(li),
        .load_data(), .load_base(lb), .prog_start(prog_start), .erase_start(erase_start),
        .eng_done(eng_done), .eng_fail(eng_fail), .eng_count_over(eng_count_over),
        .program_enable_flag(program_enable_flag), .fmc1_write_enable(fmc1_write_enable),
        .cmd_ready(cmd_ready));
    fps_engine_model eng_u (
        .sys_clk(sys_clk), .prog_start(prog_start), .erase_start(erase_start), .lat(lat),
        .fail_cfg(fail_cfg), .over_cfg(over_cfg), .mem_addr(mem_addr), .eng_done(eng_done),
        .eng_fail(eng_fail), .eng_count_over(eng_count_over), .mem_rdata(mem_rdata));
    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic cmp8(input logic [7:0] g, input logic [7:0] w);
        compares++;
        if (g !== w) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, w);
        end
    endtask
    task automatic cmp1(input logic g, input logic w);
        compares++;
        if (g !== w) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, w);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One command write: taken at the edge that sees write enable back high
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        ce_n    <= 1'b0;
        we_n    <= 1'b0;
        addr    <= a;
        data_in <= d;
        @(posedge sys_clk);
        we_n <= 1'b1;
        @(posedge sys_clk);
        ce_n <= 1'b1;
    endtask
    // One read; the note holds {status mask, driven, value}
    task automatic rd(input logic [17:0] a, input logic [9:0] n, input logic cs);
        @(posedge sys_clk);
        addr <= a;
        @(posedge sys_clk);
        ce_n <= cs;
        oe_n <= 1'b0;
        exp_q.push_back(n);
        @(posedge sys_clk);
        look <= 1'b1;
        @(posedge sys_clk);
        look <= 1'b0;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
    endtask
    // Output watcher; reserved status bits are masked off since nothing defines them
    always @(posedge sys_clk)
        if (look === 1'b1) begin
            e = exp_q.pop_front();
            m = e[9] ? 8'hf3 : 8'hff;
            cmp1(data_oe_n, !e[8]);
            if (e[8]) cmp8(data_out & m, e[7:0] & m);
        end
    // Page byte loads seen toward the engine; cleared by the stimulus per operation
    always @(posedge sys_clk)
        if (lw === 1'b1) lcnt++;
    // Watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end
    initial begin
        {rst_n, look, fail_cfg, over_cfg, program_enable_flag} = 5'h00;
        {ce_n, oe_n, we_n} = 3'h7;
        addr = 18'h00000;
        data_in = 8'h00;
        lat = 8'h14;
        bad_count = 0;
        compares = 0;
        void'($urandom(95163));
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        wr(18'h00000, 8'h71);
        rd(18'h01234, 10'h000, 1'b0);
        rd(18'h01234, 10'h000, 1'b1);
        cmp1(cmd_ready, 1'b0);
        for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
        cmp1(cmd_ready, 1'b1);
        rd(18'h01234, 10'h191, 1'b0);
        // Erase first, each page programmed once, then a final failing erase
        for (i = 0; i < 6; i++) begin
            t = tbl[i];
            base = {11'(i * 3 + 1), 7'h00} | {15'h0000, t[18], 1'b0, t[18]};
            lat <= 8'($urandom_range(60, 20));
            fail_cfg <= t[17];
            over_cfg <= t[16];
            program_enable_flag <= 1'($urandom);
            lcnt = 0;
            if (t[19]) begin
                wr(base, 8'h20);
                wr(base, 8'h20);
            end else begin
                wr(base, 8'h40);
                for (j = 0; j < 128; j++) wr(base + 18'(j), 8'($urandom));
            end
            rd(base, 10'h100, 1'b0);
            cmp1(fmc1_write_enable, program_enable_flag);
            cmp8(8'(lcnt), t[19] ? 8'h00 : 8'h80);
            if (!t[19]) cmp8(lb[7:0], base[7:0]);
            if (!t[19]) cmp8({1'b0, li}, 8'h7f);
            @(posedge sys_clk);
            ce_n <= 1'b0;
            oe_n <= 1'b0;
            for (j = 0; j < 100 && eng_done !== 1'b1; j++) @(posedge sys_clk);
            repeat (3) @(posedge sys_clk);
            rd(base, {2'b01, t[15:8]}, 1'b0);
            rd(base, {2'b01, t[15:8]}, 1'b0);
            wr(base, 8'h71);
            repeat (800) @(posedge sys_clk);
            rd(base, {2'b11, t[7:0]}, 1'b0);
            wr(base, 8'h71);
            repeat (800) @(posedge sys_clk);
            rd(base, {2'b11, t[7:0]}, 1'b0);
        end
        // Unknown command flags an error; a read command clears the code
        wr(18'h01234, 8'h5a);
        wr(18'h01234, 8'h71);
        repeat (800) @(posedge sys_clk);
        rd(18'h01234, 10'h3c0, 1'b0);
        wr(18'h01234, 8'h00);
        rd(18'h01234, 10'h191, 1'b0);
        wr(18'h01234, 8'h71);
        repeat (800) @(posedge sys_clk);
        rd(18'h01234, 10'h300, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
